// file: rtl/slf_check.sv
// Store buffer with store-to-load forward check and misalignment class.
// Assumes pipelines on the same clock; entries allocated in program order.
`include "slf_regs.svh"
module slf_check #(
  parameter int DEPTH = `SLF_SB_DEPTH
) (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     ce_in,
  // Store allocate
  input  wire logic                     st_valid_in,
  input  wire slf_pkg::slf_store_t      st_in,
  output logic                          st_ready_out,
  // Retire level from the reorder buffer for the head store
  input  wire logic                     rob_retired_in,
  // Cache write port
  output logic                          dc_wr_out,
  output logic [`SLF_VA_W-1:0]          dc_addr_out,
  input  wire logic                     dc_ack_in,
  // Load lookup
  input  wire logic                     ld_valid_in,
  input  wire slf_pkg::slf_load_t       ld_in,
  input  wire logic                     align_mask_in,
  output logic                          fwd_valid_out,
  output logic [255:0]                  fwd_data_out,
  output logic                          ld_replay_out,
  output logic                          ld_cache_out,
  output logic [7:0]                    ld_tag_out,
  output slf_pkg::slf_class_t           ld_class_out,
  output logic                          align_fault_out
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [5:0] size_bytes(slf_pkg::slf_size_t s);
    case (s)
      slf_pkg::SZ_BYTE:   size_bytes = 6'd1;
      slf_pkg::SZ_WORD:   size_bytes = 6'd2;
      slf_pkg::SZ_DWORD:  size_bytes = 6'd4;
      slf_pkg::SZ_QWORD:  size_bytes = 6'd8;
      slf_pkg::SZ_TBYTE:  size_bytes = 6'd10;
      slf_pkg::SZ_DQWORD: size_bytes = 6'd16;
      default:            size_bytes = 6'd32;
    endcase
  endfunction

  // Alignment step: tbyte aligns to 8, not 10
  function automatic logic [5:0] align_of(slf_pkg::slf_size_t s);
    align_of = (s == slf_pkg::SZ_TBYTE) ? 6'd8 : size_bytes(s);
  endfunction

  function automatic logic is_aligned(logic [`SLF_VA_W-1:0] a, slf_pkg::slf_size_t s);
    is_aligned = ((a[5:0] & (align_of(s) - 6'd1)) == 6'h00);
  endfunction

  // Dwords of one 16-byte bank touched; a bank crosser is seen in its first bank only
  function automatic logic [3:0] dw_mask(logic [3:0] off, slf_pkg::slf_size_t s);
    logic [5:0] last;
    last    = 6'(off) + size_bytes(s) - 6'd1;
    dw_mask = 4'h0;
    for (int q = 0; q < 4; q++) begin
      if (q >= int'(off[3:2]) && q <= int'(last[5:2])) begin
        dw_mask[q] = 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Store buffer control
  logic [`SLF_VA_W-1:0] addr_q [DEPTH];
  logic [`SLF_VA_W-1:0] addr_d [DEPTH];
  slf_pkg::slf_size_t   size_q [DEPTH];
  slf_pkg::slf_size_t   size_d [DEPTH];
  logic [DEPTH-1:0]     vld_q, vld_d;
  logic [AW-1:0]        head_q, head_d, tail_q, tail_d;
  logic [AW:0]          cnt_q, cnt_d;
  logic                 push, pop;

  assign push = st_valid_in && st_ready_out;
  // Head store writes the cache only once the reorder buffer says it retired
  assign pop  = dc_wr_out && dc_ack_in;

  always_comb begin
    addr_d = addr_q;
    size_d = size_q;
    vld_d  = vld_q;
    head_d = head_q;
    tail_d = tail_q;
    cnt_d  = cnt_q;
    if (push) begin
      addr_d[tail_q] = st_in.addr;
      size_d[tail_q] = st_in.size;
      vld_d[tail_q]  = 1'b1;
      tail_d         = AW'(tail_q + 1'b1);
    end
    if (pop) begin
      vld_d[head_q] = 1'b0;
      head_d        = AW'(head_q + 1'b1);
    end
    cnt_d = AW'(0) + cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vld_q  <= '0;
      head_q <= '0;
      tail_q <= '0;
      cnt_q  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        addr_q[i] <= '0;
        size_q[i] <= slf_pkg::SZ_BYTE;
      end
    end else if (ce_in) begin
      vld_q  <= vld_d;
      head_q <= head_d;
      tail_q <= tail_d;
      cnt_q  <= cnt_d;
      addr_q <= addr_d;
      size_q <= size_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forward search, oldest first so the youngest overlap wins
  logic           hit, refuse, mis_ld, dw_hi, dw_lo, ovl;
  logic [AW-1:0]  hit_idx, j;
  logic [3:0]     ld_dw, st_dw;
  logic [5:0]     lb, sb_sz;
  logic [7:0]     end_off;
  logic [12:0]    end_pg;

  always_comb begin
    hit     = 1'b0;
    refuse  = 1'b0;
    hit_idx = '0;
    j       = '0;
    ovl     = 1'b0;
    st_dw   = 4'h0;
    ld_dw   = dw_mask(ld_in.addr[3:0], ld_in.size);
    dw_hi   = 1'b0;
    dw_lo   = 1'b0;
    sb_sz   = '0;
    lb      = size_bytes(ld_in.size);
    mis_ld  = !is_aligned(ld_in.addr, ld_in.size);
    // Oldest to youngest so the youngest overlap is last to win
    for (int k = 0; k < DEPTH; k++) begin
      j     = AW'(head_q + AW'(k));
      sb_sz = size_bytes(size_q[j]);
      st_dw = dw_mask(addr_q[j][3:0], size_q[j]);
      // Bits 4..11 with shared dwords, then the upper bits
      ovl = vld_q[j] && (addr_q[j][11:4] == ld_in.addr[11:4])
            && ((st_dw & ld_dw) != 4'h0)
            && (addr_q[j][`SLF_VA_W-1:12] == ld_in.addr[`SLF_VA_W-1:12]);
      if (vld_q[j] && addr_q[j][`SLF_VA_W-1:2] == ld_in.addr[`SLF_VA_W-1:2]
          && sb_sz <= 6'd2) begin
        if (addr_q[j][1:0] != 2'b00) dw_hi = 1'b1;
        else                         dw_lo = 1'b1;
      end
      if (ovl) begin
        hit     = 1'b1;
        hit_idx = j;
        refuse  = (addr_q[j] != ld_in.addr)
                  || (lb > sb_sz)
                  || mis_ld || !is_aligned(addr_q[j], size_q[j]);
      end
    end
    if (hit && lb <= 6'd2 && dw_hi && dw_lo) refuse = 1'b1;
  end

  // Forward data lands one cycle later from the registered array
  slf_sb_mem #(.DEPTH(DEPTH), .W(256)) u_mem (
    .clk_in    (clk_in),
    .ce_in     (ce_in),
    .we_in     (push),
    .waddr_in  (tail_q),
    .wdata_in  (st_in.data),
    .raddr_in  (hit_idx),
    .rdata_out (fwd_data_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Load result and misalignment class
  logic       fwd_d, rep_d, cache_d, flt_d;
  logic [7:0] tag_d;
  slf_pkg::slf_class_t cls_d;

  always_comb begin
    end_off = 8'(ld_in.addr[6:0]) + 8'(lb) - 8'd1;
    end_pg  = 13'(ld_in.addr[11:0]) + 13'(lb) - 13'd1;
    cls_d.misaligned = ld_valid_in && (end_off >= 8'(`SLF_BLOCK_BYTES));
    cls_d.line_cross = cls_d.misaligned &&
                       ((7'(ld_in.addr[5:0]) + 7'(lb) - 7'd1) >= 7'(`SLF_LINE_BYTES));
    cls_d.page_cross = cls_d.misaligned &&
                       (end_pg >= 13'(`SLF_PAGE_BYTES));
    cls_d.penalty    = 2'd0;
    if (ld_valid_in && mis_ld) cls_d.penalty = 2'(`SLF_BASE_PENALTY);
    if (ld_valid_in && mis_ld && lb >= 6'd16)
      cls_d.penalty = 2'(`SLF_BASE_PENALTY + `SLF_WIDE_PENALTY);
    fwd_d   = ld_valid_in && hit && !refuse;
    // Refused load is replayed until the store drains, then goes to cache
    rep_d   = ld_valid_in && hit && refuse;
    cache_d = ld_valid_in && !hit;
    tag_d   = ld_in.tag;
    flt_d   = ld_valid_in && align_mask_in && mis_ld;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fwd_valid_out   <= 1'b0;
      ld_replay_out   <= 1'b0;
      ld_cache_out    <= 1'b0;
      ld_tag_out      <= '0;
      ld_class_out    <= '0;
      align_fault_out <= 1'b0;
      st_ready_out    <= 1'b0;
      dc_wr_out       <= 1'b0;
      dc_addr_out     <= '0;
    end else if (ce_in) begin
      fwd_valid_out   <= fwd_d;
      ld_replay_out   <= rep_d;
      ld_cache_out    <= cache_d;
      ld_tag_out      <= tag_d;
      ld_class_out    <= cls_d;
      align_fault_out <= flt_d;
      // Conservative: leaves one slot spare for the in-flight push
      st_ready_out    <= (cnt_d < (AW+1)'(DEPTH - 1));
      // Held until acknowledged; one cycle off after a pop so that the
      // retire level seen next belongs to the new head
      dc_wr_out       <= !pop && (dc_wr_out || (vld_d[head_d] && rob_retired_in));
      dc_addr_out     <= addr_d[head_d];
    end
  end
endmodule // slf_check

// file: rtl/slf_pkg.sv
// Types for the store/load forward checker.
// Assumes slf_regs.svh sits beside it.
`include "slf_regs.svh"
package slf_pkg;
  typedef enum logic [2:0] {
    SZ_BYTE, SZ_WORD, SZ_DWORD, SZ_QWORD, SZ_TBYTE, SZ_DQWORD, SZ_QQWORD
  } slf_size_t;
  typedef struct packed {
    logic [`SLF_VA_W-1:0] addr;
    slf_size_t            size;
    logic [255:0]         data;
  } slf_store_t;
  typedef struct packed {
    logic [`SLF_VA_W-1:0] addr;
    slf_size_t            size;
    logic [7:0]           tag;
  } slf_load_t;
  typedef struct packed {
    logic       misaligned;
    logic       line_cross;
    logic       page_cross;
    logic [1:0] penalty;
  } slf_class_t;
endpackage

// file: rtl/slf_regs.svh
// Constants for the store/load forward checker.
// Assumes inclusion by the package and the design files.
`ifndef SLF_REGS_SVH
`define SLF_REGS_SVH
`define SLF_BLOCK_BYTES   128
`define SLF_LINE_BYTES    64
`define SLF_PAGE_BYTES    4096
`define SLF_VA_W          48
`define SLF_SB_DEPTH      8
`define SLF_BASE_PENALTY  1
`define SLF_WIDE_PENALTY  1
`endif

// file: rtl/slf_sb_mem.sv
// Store-buffer data array, registered read.
// Assumes one write and one read port on one clock.
`include "slf_regs.svh"
module slf_sb_mem #(
  parameter int DEPTH = `SLF_SB_DEPTH,
  parameter int W     = 256
) (
  // Clock
  input  wire logic                     clk_in,
  input  wire logic                     ce_in,
  // Write
  input  wire logic                     we_in,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_in,
  input  wire logic [W-1:0]             wdata_in,
  // Read
  input  wire logic [$clog2(DEPTH)-1:0] raddr_in,
  output logic      [W-1:0]             rdata_out
);
  logic [W-1:0] mem_q [DEPTH];
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (we_in) begin
        mem_q[waddr_in] <= wdata_in;
      end
      rdata_out <= mem_q[raddr_in];
    end
  end
endmodule // slf_sb_mem

// file: testbench/slf_check_asserts.sv
// Checker for slf_check load answers, load class and store drain.
// Assumes bind from the bench top; one clock domain.
module slf_check_asserts (
  input wire logic                clk_in,
  input wire logic                rst_n_in,
  input wire logic                ce_in,
  input wire logic                ld_valid_in,
  input wire slf_pkg::slf_load_t  ld_in,
  input wire logic                align_mask_in,
  input wire logic                rob_retired_in,
  input wire logic                dc_ack_in,
  input wire logic                dc_wr_out,
  input wire logic [47:0]         dc_addr_out,
  input wire logic                fwd_valid_out,
  input wire logic                ld_replay_out,
  input wire logic                ld_cache_out,
  input wire logic [7:0]          ld_tag_out,
  input wire slf_pkg::slf_class_t ld_class_out,
  input wire logic                align_fault_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire       tk    = ld_valid_in && ce_in;
  wire [7:0] tg    = ld_in.tag;
  wire [2:0] ans   = {fwd_valid_out, ld_replay_out, ld_cache_out};
  wire       odd_w = ld_in.size == slf_pkg::SZ_WORD && ld_in.addr[0];
  a_one_answer: assert property (tk |=> $onehot(ans))
    else $error("load answer not single");
  a_idle_quiet: assert property (!tk |=> ans == 3'h0)
    else $error("answer without load");
  a_tag_echo: assert property (tk |=> ld_tag_out == $past(tg))
    else $error("tag not echoed");
  a_odd_nofwd: assert property (tk && odd_w |=> !fwd_valid_out)
    else $error("odd word forwarded");
  a_odd_pen: assert property (tk && odd_w |=> ld_class_out.penalty != 2'h0)
    else $error("misaligned load without penalty");
  a_fault_flag: assert property (tk && odd_w && align_mask_in |=> align_fault_out)
    else $error("alignment fault missing");
  a_wide_pen: assert property (tk && ld_in.size == slf_pkg::SZ_DQWORD
    && ld_in.addr[3:0] == 4'h8 |=> ld_class_out.penalty == 2'h2) else $error("wide penalty");
  a_page_cls: assert property (tk && ld_in.size == slf_pkg::SZ_DWORD
    && ld_in.addr[11:0] == 12'hffe |=> ld_class_out == 5'b1_1101)
    else $error("page crosser class wrong");
  a_drain_gate: assert property ($rose(dc_wr_out) |-> $past(rob_retired_in))
    else $error("drain before retire");
  a_wr_hold: assert property (dc_wr_out && !dc_ack_in && ce_in |=> dc_wr_out
    && $stable(dc_addr_out)) else $error("cache write dropped");
  c_fwd: cover property (fwd_valid_out);
  c_replay: cover property (ld_replay_out);
  c_drain: cover property (dc_wr_out && dc_ack_in);
endmodule // slf_check_asserts

// file: testbench/slf_check_tb.sv
// Bench for slf_check: forwards, refusals, drain and load class.
// Assumes the checker and the cache model are compiled first.
module slf_check_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] F = 3'h4, R = 3'h2, C = 3'h1;
  logic                clk_in = 1'b0, rst_n_in = 1'b0, st_valid_in = 1'b0;
  logic                rob_retired_in = 1'b0, ld_valid_in = 1'b0, align_mask_in = 1'b0;
  slf_pkg::slf_store_t st_in = '0;
  slf_pkg::slf_load_t  ld_in = '0;
  logic                st_ready_out, dc_wr_out, dc_ack_in, fwd_valid_out;
  logic                ld_replay_out, ld_cache_out, align_fault_out;
  logic [47:0]         dc_addr_out;
  logic [255:0]        fwd_data_out, da, db;
  logic [7:0]          ld_tag_out;
  slf_pkg::slf_class_t ld_class_out;
  logic [1:0]          dly = 2'h3;
  logic [266:0]        exp_q[$];
  logic [47:0]         drn_q[$];
  int                  err_total = 0, n_checks = 0, idle;
  always #20 clk_in = ~clk_in;
  slf_check DUT (.clk_in, .rst_n_in, .ce_in(1'b1), .st_valid_in, .st_in, .st_ready_out,
    .rob_retired_in, .dc_wr_out, .dc_addr_out, .dc_ack_in, .ld_valid_in, .ld_in,
    .align_mask_in, .fwd_valid_out, .fwd_data_out, .ld_replay_out, .ld_cache_out,
    .ld_tag_out, .ld_class_out, .align_fault_out);
  slf_dc_model u_dc (.clk_in, .rst_n_in, .dc_wr_in(dc_wr_out), .dly_in(dly), .ack_out(dc_ack_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [266:0] seen, input logic [266:0] want);
    n_checks++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic st(input logic [47:0] a, input slf_pkg::slf_size_t s, input logic [255:0] d);
    ld_valid_in = 1'b0;
    st_valid_in = 1'b1;
    st_in = '{addr: a, size: s, data: d};
    drn_q.push_back(a);
    do @(posedge clk_in); while (!st_ready_out);
    #1;
  endtask
  task automatic ld(input logic [47:0] a, input slf_pkg::slf_size_t s, input logic [2:0] k,
                    input logic [255:0] d);
    logic [7:0] t;
    t = 8'($urandom);
    st_valid_in = 1'b0;
    ld_valid_in = 1'b1;
    ld_in = '{addr: a, size: s, tag: t};
    exp_q.push_back({k, t, d});
    @(posedge clk_in);
    #1;
  endtask
  task automatic print_verdict;
    if (exp_q.size() != 0 || drn_q.size() != 0)
      err_total++;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Answers pair with notes in load order
  always @(posedge clk_in) begin
    if (fwd_valid_out || ld_replay_out || ld_cache_out)
      chk({fwd_valid_out, ld_replay_out, ld_cache_out, ld_tag_out, fwd_valid_out ? fwd_data_out
        : 256'h0}, exp_q.size() ? exp_q.pop_front() : 267'h0);
  end
  // Cache writes leave in program order
  always @(posedge clk_in) begin
    if (dc_wr_out && dc_ack_in)
      chk(267'(dc_addr_out), drn_q.size() ? 267'(drn_q.pop_front()) : '1);
  end
  initial begin
    repeat (4000) @(posedge clk_in);
    err_total++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h313a));
    repeat (16) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk(267'(st_ready_out), 267'h1);
    da = {8{$urandom}};
    db = {8{$urandom}};
    st(48'h0000_0000_0100, slf_pkg::SZ_QWORD, da);
    st(48'h0000_0000_0100, slf_pkg::SZ_QWORD, db);
    ld(48'h0000_0000_0100, slf_pkg::SZ_QWORD, F, db);
    ld(48'h0000_0000_0100, slf_pkg::SZ_DWORD, F, db);
    ld(48'h0000_0000_0100, slf_pkg::SZ_DQWORD, R, '0);
    ld(48'h0000_0000_0104, slf_pkg::SZ_DWORD, R, '0);
    ld(48'h0000_0000_2000, slf_pkg::SZ_DWORD, C, '0);
    $display("test 1 done");
    st(48'h0000_0000_0204, slf_pkg::SZ_QWORD, da);
    ld(48'h0000_0000_0204, slf_pkg::SZ_QWORD, R, '0);
    st(48'h0000_0000_0300, slf_pkg::SZ_BYTE, da);
    st(48'h0000_0000_0301, slf_pkg::SZ_BYTE, db);
    ld(48'h0000_0000_0300, slf_pkg::SZ_BYTE, R, '0);
    ld_valid_in = 1'b0;
    chk(267'(dc_wr_out), 267'h0);
    $display("test 2 done");
    rob_retired_in = 1'b1;
    idle = 0;
    for (int i = 0; i < 300 && idle < 6; i++) begin
      @(posedge clk_in);
      idle = dc_wr_out ? 0 : idle + 1;
    end
    #1;
    ld(48'h0000_0000_0100, slf_pkg::SZ_QWORD, C, '0);
    ld(48'h0000_0000_0300, slf_pkg::SZ_BYTE, C, '0);
    $display("test 3 done");
    dly = 2'h0;
    align_mask_in = 1'b1;
    st(48'h0000_0000_0400, slf_pkg::SZ_DWORD, da);
    ld(48'h0000_0000_0400, slf_pkg::SZ_DWORD, F, da);
    ld(48'h0000_0000_0ffe, slf_pkg::SZ_DWORD, C, '0);
    ld(48'h0000_0000_5008, slf_pkg::SZ_DQWORD, C, '0);
    ld(48'h0000_0000_6003, slf_pkg::SZ_WORD, C, '0);
    for (int i = 0; i < 8; i++)
      ld({16'h0001, 32'($urandom)}, slf_pkg::slf_size_t'($urandom_range(0, 6)), C, '0);
    ld_valid_in = 1'b0;
    repeat (3) @(posedge clk_in);
    $display("test 4 done");
    print_verdict();
  end
endmodule // slf_check_tb
bind slf_check slf_check_asserts u_sva (.clk_in, .rst_n_in, .ce_in, .ld_valid_in, .ld_in,
  .align_mask_in, .rob_retired_in, .dc_ack_in, .dc_wr_out, .dc_addr_out, .fwd_valid_out,
  .ld_replay_out, .ld_cache_out, .ld_tag_out, .ld_class_out, .align_fault_out);

// file: testbench/slf_dc_model.sv
// Data cache write responder for the store drain port.
// Assumes the bench picks a prompt or slow acknowledge.
module slf_dc_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       dc_wr_in,
  input  wire logic [1:0] dly_in,
  output logic            ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q   <= 2'h0;
      ack_out <= 1'b0;
    end else if (dc_wr_in && !ack_out && cnt_q >= dly_in) begin
      ack_out <= 1'b1;
    end else begin
      // One-cycle pulse; a held ack would pop the next head too
      ack_out <= 1'b0;
      cnt_q   <= (dc_wr_in && !ack_out) ? cnt_q + 2'h1 : 2'h0;
    end
  end
endmodule // slf_dc_model
